// ===== verilog/rheostat_serial_pkg.sv
// Shared constants for the rheostat serial frame port
package rheostat_serial_pkg;

  // ==========================================================================
  // Frame layout
  localparam int FRAME_BITS = 16;
  localparam int CMD_MSB = 13;
  localparam int CMD_LSB = 10;
  localparam int DATA_MSB = 9;
  localparam int DATA_LSB = 0;
  localparam logic [3:0] BIT_COUNT_LAST = 4'hf;
  localparam logic [3:0] BIT_COUNT_ZERO = 4'h0;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SYNC_HIGH_MIN_NS = 500;
  // Cycles to let the synchronised frame status settle after the frame ends
  localparam logic [2:0] SETTLE_CYCLES = 3'h2;
  // Link clear pulse length, well inside the least frame sync high time
  localparam int CLEAR_CYCLES_INT = (SYNC_HIGH_MIN_NS * 1000) / CLK_PERIOD_PS / 25;
  localparam logic [2:0] CLEAR_CYCLES = CLEAR_CYCLES_INT[2:0];

  // ==========================================================================
  // Frame-end states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETTLE,
    ST_DECIDE,
    ST_CLEAR
  } frame_state_e;

endpackage : rheostat_serial_pkg

// ===== verilog/rheostat_serial_frame_port.sv
// Serial slave frame port: link-side shift register and system-side word hand-off
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Clock idles low, data sampled second edge
// - Data input sampled on falling serial clock
// - Shifting enabled only while frame sync low
// - Received frame held in 16-bit register
// - Word committed at frame end after 16th clock
// - Early frame end aborts, nothing updated
// - Serial output open drain, never driven high
// - Shift register contents shifted out serially
// - Frame: two zeros, four command, ten data
// - Only whole multiples of 16 bits accepted
// - Word decoded when frame sync returns high
module rheostat_serial_frame_port (
  // System clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Serial link pins
  input wire logic SCLK,
  input wire logic SYNC_N,
  input wire logic DIN,
  input wire logic SDO_IN,
  output logic SDO_OUT,
  output logic SDO_OE,
  // Received word towards the command decoder
  output logic [rheostat_serial_pkg::FRAME_BITS-1:0] WORD,
  output logic [rheostat_serial_pkg::CMD_MSB-rheostat_serial_pkg::CMD_LSB:0] COMMAND,
  output logic [rheostat_serial_pkg::DATA_MSB:0] DATA,
  output logic WORD_VALID,
  output logic FRAME_ABORT
);
  import rheostat_serial_pkg::*;

  // ==========================================================================
  // Link domain (serial clock)
  logic link_clr;
  logic [15:0] shift_reg;
  logic [15:0] next_shift_reg;
  logic [15:0] held_word;
  logic [15:0] next_held_word;
  logic [3:0] bit_count;
  logic [3:0] next_bit_count;
  logic have_word;
  logic next_have_word;
  logic frame_whole;
  logic next_frame_whole;
  logic out_bit;
  logic next_out_bit;

  // Shift, count and capture on each falling edge of an active frame
  always_comb begin
    next_shift_reg = shift_reg;
    next_held_word = held_word;
    next_bit_count = bit_count;
    next_have_word = have_word;
    if (!SYNC_N) begin
      next_shift_reg = {shift_reg[14:0], DIN};
      next_bit_count = bit_count + 4'h1;
      if (bit_count == BIT_COUNT_LAST) begin
        next_held_word = {shift_reg[14:0], DIN};
        next_have_word = 1'b1;
      end
    end
    // Whole frame only when the count has wrapped back to a 16-bit boundary
    next_frame_whole = next_have_word && (next_bit_count == BIT_COUNT_ZERO);
  end

  // Falling-edge link registers, cleared by the system side between frames
  always_ff @(negedge SCLK or posedge link_clr) begin
    if (link_clr) begin
      shift_reg <= WORD_RESET;
      held_word <= WORD_RESET;
      bit_count <= BIT_COUNT_ZERO;
      have_word <= 1'b0;
      frame_whole <= 1'b0;
    end else begin
      shift_reg <= next_shift_reg;
      held_word <= next_held_word;
      bit_count <= next_bit_count;
      have_word <= next_have_word;
      frame_whole <= next_frame_whole;
    end
  end

  // Oldest bit of the shift register, received sixteen falls ago
  always_comb begin
    next_out_bit = shift_reg[15];
  end

  // Output bit launched on the rising edge, host samples on the next fall
  always_ff @(posedge SCLK or posedge link_clr) begin
    if (link_clr) begin
      out_bit <= 1'b1;
    end else begin
      out_bit <= next_out_bit;
    end
  end

  // Open drain: pull low for a zero, release otherwise
  assign SDO_OUT = 1'b0;
  assign SDO_OE = !out_bit && !SYNC_N;

  // ==========================================================================
  // System domain: synchronisers
  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic whole_a;
  logic whole_b;
  logic next_sync_a;
  logic next_sync_b;
  logic next_sync_c;
  logic next_whole_a;
  logic next_whole_b;

  // Each stage takes the one before it; only the second stage reads the first
  always_comb begin
    next_sync_a = SYNC_N;
    next_sync_b = sync_a;
    next_sync_c = sync_b;
    next_whole_a = frame_whole;
    next_whole_b = whole_a;
  end

  // Two-flop synchronisers for frame sync and the whole-frame status
  always_ff @(posedge CLK) begin
    sync_a <= next_sync_a;
    sync_b <= next_sync_b;
    sync_c <= next_sync_c;
    whole_a <= next_whole_a;
    whole_b <= next_whole_b;
  end

  // ==========================================================================
  // System domain: frame-end decision
  frame_state_e state;
  frame_state_e next_state;
  logic [2:0] wait_count;
  logic [2:0] next_wait_count;
  logic next_link_clr;
  logic [15:0] next_word;
  logic next_word_valid;
  logic next_frame_abort;

  // Frame end seen, settle, then commit or abort, then clear the link side
  // The held word needs no synchroniser: it last moved before frame sync rose
  // and stays put until the link clear, which comes after it is taken
  always_comb begin
    next_state = state;
    next_wait_count = wait_count;
    next_word = WORD;
    next_word_valid = 1'b0;
    next_frame_abort = 1'b0;
    next_link_clr = 1'b0;
    case (state)
      ST_IDLE: begin
        if (sync_b && !sync_c) begin
          next_state = ST_SETTLE;
          next_wait_count = SETTLE_CYCLES;
        end
      end
      ST_SETTLE: begin
        next_wait_count = wait_count - 3'h1;
        if (wait_count == 3'h1) begin
          next_state = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        if (whole_b) begin
          next_word = held_word;
          next_word_valid = 1'b1;
        end else begin
          next_frame_abort = 1'b1;
        end
        next_state = ST_CLEAR;
        next_wait_count = CLEAR_CYCLES;
        next_link_clr = 1'b1;
      end
      ST_CLEAR: begin
        next_wait_count = wait_count - 3'h1;
        next_link_clr = 1'b1;
        if (wait_count == 3'h1) begin
          next_state = ST_IDLE;
          next_link_clr = 1'b0;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Registers of the frame-end logic
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      state <= ST_IDLE;
      wait_count <= 3'h0;
      link_clr <= 1'b1;
      WORD <= WORD_RESET;
      WORD_VALID <= 1'b0;
      FRAME_ABORT <= 1'b0;
    end else begin
      state <= next_state;
      wait_count <= next_wait_count;
      link_clr <= next_link_clr;
      WORD <= next_word;
      WORD_VALID <= next_word_valid;
      FRAME_ABORT <= next_frame_abort;
    end
  end

  // Field split of the committed word
  assign COMMAND = WORD[CMD_MSB:CMD_LSB];
  assign DATA = WORD[DATA_MSB:DATA_LSB];

endmodule : rheostat_serial_frame_port
`default_nettype wire

// ===== testbench/rheostat_serial_frame_port_asserts.sv
// Checker for the rheostat serial frame port
`timescale 1ns/10ps
`default_nettype none
module rheostat_serial_frame_port_asserts import rheostat_serial_pkg::*; (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Serial link
  input wire logic SYNC_N,
  input wire logic SDO_OUT,
  input wire logic SDO_OE,
  // Word hand-off
  input wire logic WORD_VALID,
  input wire logic FRAME_ABORT,
  input wire logic [FRAME_BITS-1:0] WORD,
  input wire logic [CMD_MSB-CMD_LSB:0] COMMAND,
  input wire logic [DATA_MSB:0] DATA
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // ==========================================================================
  // Line and word checks
  od_only_a: assert property (SDO_OUT == 1'b0) else $error("sdo high");
  out_idle_a: assert property (SYNC_N |-> !SDO_OE) else $error("sdo held");
  first_bit_a: assert property ($fell(SYNC_N) |-> !SDO_OE) else $error("sdo early");
  cmd_field_a: assert property (COMMAND == WORD[CMD_MSB:CMD_LSB]) else $error("cmd");
  data_field_a: assert property (DATA == WORD[DATA_MSB:DATA_LSB]) else $error("data");
  word_commit_a: assert property (!$stable(WORD) |-> WORD_VALID) else $error("word");
  one_pulse_a: assert property (WORD_VALID |=> !WORD_VALID && !FRAME_ABORT) else $error("pulse");
  end_sync_a: assert property ((WORD_VALID || FRAME_ABORT) |-> SYNC_N && $past(SYNC_N, 4))
    else $error("early end");
  end_bound_a: assert property ($rose(SYNC_N) |-> ##[4:10] (WORD_VALID || FRAME_ABORT))
    else $error("no end");
  // Main scenarios
  cover property (WORD_VALID);
  cover property (FRAME_ABORT);
  cover property (SDO_OE);
endmodule : rheostat_serial_frame_port_asserts
bind rheostat_serial_frame_port rheostat_serial_frame_port_asserts u_chk (.CLK(CLK),
  .RESET_N(RESET_N), .SYNC_N(SYNC_N), .SDO_OUT(SDO_OUT), .SDO_OE(SDO_OE),
  .WORD_VALID(WORD_VALID), .FRAME_ABORT(FRAME_ABORT), .WORD(WORD), .COMMAND(COMMAND),
  .DATA(DATA));
`default_nettype wire

// ===== testbench/rheostat_link_host.sv
// Serial host model: drives frames, samples the return line
`timescale 1ns/10ps
`default_nettype none
module rheostat_link_host #(
  parameter int HALF_NS = 40
) (
  // Link pins
  output var logic sclk,
  output var logic sync_n,
  output var logic din,
  input wire logic sdo_line
);
  // Idle: clock still low, no frame
  initial begin
    sclk = 1'b0;
    sync_n = 1'b1;
    din = 1'b0;
  end
  // One frame, top bit first; returns the sampled line bits
  task automatic xfer(input int n, input logic [31:0] w, output logic [31:0] rb);
    rb = '0;
    sync_n = 1'b0;
    #(HALF_NS);
    for (int i = n - 1; i >= 0; i--) begin
      din = w[i];
      sclk = 1'b1;
      #(HALF_NS);
      sclk = 1'b0;
      rb = {rb[30:0], sdo_line};
      #(HALF_NS);
    end
    sync_n = 1'b1;
    din = ~din; // No stale level once released
    #(15 * HALF_NS);
  endtask : xfer
endmodule : rheostat_link_host
`default_nettype wire

// ===== testbench/rheostat_serial_frame_port_tb_top.sv
// Self-checking bench for the rheostat serial frame port
`timescale 1ns/10ps
`default_nettype none
module rheostat_serial_frame_port_tb_top;
  logic clk, reset_n;
  wire sclk, sync_n, din, sdo_out, sdo_oe, sdo_line, valid, abort;
  wire [15:0] word;
  wire [3:0] cmd;
  wire [9:0] data;
  logic [31:0] exp_q[$];
  logic [31:0] w, rb, e;
  int error_cnt = 0, n_checks = 0, n;
  int abort_len[3] = '{0, 9, 15};
  // Pull-up on the open-drain line
  assign sdo_line = sdo_oe ? sdo_out : 1'b1;
  rheostat_serial_frame_port dut (.CLK(clk), .RESET_N(reset_n), .SCLK(sclk), .SYNC_N(sync_n),
    .DIN(din), .SDO_IN(sdo_line), .SDO_OUT(sdo_out), .SDO_OE(sdo_oe), .WORD(word),
    .COMMAND(cmd), .DATA(data), .WORD_VALID(valid), .FRAME_ABORT(abort));
  rheostat_link_host host (.sclk(sclk), .sync_n(sync_n), .din(din), .sdo_line(sdo_line));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("Mismatches %0d, checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  // Clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Result monitor, mid-cycle
  always @(negedge clk) begin
    if (valid === 1'b1 || abort === 1'b1) begin
      e = exp_q.pop_front();
      check("word", {15'h0000, abort, word}, e);
      check("command", cmd, e[13:10]);
      check("data", data, e[9:0]);
    end
  end
  // Watchdog
  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end
  // Stimulus
  initial begin
    reset_n = 1'b0;
    w = $urandom(32'hae36);
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    #3;
    for (int k = 0; k < 5; k++) begin
      n = (k == 4) ? 32 : 16;
      w = $urandom & 32'h3fff_3fff;
      exp_q.push_back({16'h0000, w[15:0]});
      host.xfer(n, w, rb);
      check("readback", rb[15:0], (n == 32) ? w[31:16] : 32'h0000_0000);
    end
    foreach (abort_len[i]) begin
      exp_q.push_back({15'h0000, 1'b1, w[15:0]});
      host.xfer(abort_len[i], $urandom, rb);
    end
    #200;
    check("pending", exp_q.size(), 32'h0000_0000);
    end_of_test();
  end
endmodule : rheostat_serial_frame_port_tb_top
`default_nettype wire
